// ==== rtl/pmr_consts.vh ====
`ifndef PMR_CONSTS_VH
`define PMR_CONSTS_VH
// Transceiver register indices
`define PMR_REG_CTL   5'h00
`define PMR_REG_STS   5'h01
`define PMR_REG_IDH   5'h02
`define PMR_REG_IDL   5'h03
`define PMR_REG_ADV   5'h04
`define PMR_REG_LPA   5'h05
`define PMR_REG_DIAG  5'h1D
`define PMR_REG_SPEC  5'h1F
// Basic control bit positions
`define PMR_B_LOOP    14
`define PMR_B_F100    13
`define PMR_B_NEGEN   12
`define PMR_B_PDN     11
`define PMR_B_NEGRS   9
`define PMR_B_FULL    8
`define PMR_B_XALG    5
`define PMR_B_STRT    4
`define PMR_B_XDIS    3
`define PMR_B_FEFD    2
`define PMR_B_TXDIS   1
`define PMR_B_LEDDIS  0
`define PMR_CTL_RST   16'h1020
`define PMR_CTL_WMSK  16'h7B3F
// Advertisement and status
`define PMR_ADV_RST   5'h1F
`define PMR_ADV_SEL   5'h01
`define PMR_STS_FIX   16'h7808
// Host port map
`define PMR_HA_GLB    8'h0F
`define PMR_HA_P1     8'h1C
`define PMR_HA_P2     8'h2C
`define PMR_IDX_ABIL  2'h0
`define PMR_IDX_CTRL  2'h1
`define PMR_IDX_STAT  2'h2
`define PMR_IDX_SPEC  2'h3
`define PMR_GLB_RST   5'h01
// Management frame
`define PMR_PRE_LEN   6'h20
`define PMR_HDR_LAST  5'h0C
`define PMR_TA_LAST   5'h01
`define PMR_DAT_LAST  5'h0F
`define PMR_OP_RD     2'h2
`define PMR_OP_WR     2'h1
`endif

// ==== rtl/pmr_mgmt_bank.v ====
`timescale 1ns/1ps
`include "pmr_consts.vh"
// Summary of operation
// - After reset transceiver 1 answers at address 1 and transceiver 2 at address 2.
// - The transceiver addresses follow the five-bit field in bits 7:3 of global register 0x0F.
// - Register indices 0x0-0x5, 0x1D and 0x1F exist per transceiver; all others are unsupported.
// - Management frames are decoded by transceiver address and register index.
// - A host port reaches the same bits through its own byte-wide indirect map.
// - Control bit 14 set puts the port into cross-port loopback; clear means normal operation.
// - Port 1 loopback returns port 2 receive data back out of port 2.
// - Port 2 loopback returns port 1 receive data back out of port 1.
// - Control bit 4 set forces the straight pinout, transmitting on the receive pair.
// - Control bit 3 set disables automatic crossover; it resets to 0.
// - Control bit 2 set stops far-end fault detection; it resets to 0.
// - Control bit 5 selects the crossover algorithm and resets to 1.
// - Register indices 0x2 and 0x3 return fixed read-only identifier halves.
module pmr_mgmt_bank #(
    parameter [15:0] ID_HIGH = 16'h5A5A, // Arbitrary value
    parameter [15:0] ID_LOW  = 16'hC3C3  // Arbitrary value
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // Management pins
    input  wire        mdc,
    input  wire        mdio_i,
    output wire        mdio_o,
    output wire        mdio_oe,
    // Host register port
    input  wire [7:0]  hst_addr,
    input  wire        hst_we,
    input  wire [7:0]  hst_wdata,
    output wire [7:0]  hst_rdata,
    // Transceiver status, two ports
    input  wire [1:0]  link_up,
    input  wire [1:0]  neg_complete,
    input  wire [1:0]  far_end_fault,
    input  wire [9:0]  partner_ability,
    input  wire [1:0]  restart_ack,
    // Data path, four bits per port
    input  wire [7:0]  mac_tx_data,
    input  wire [7:0]  line_rx_data,
    output wire [7:0]  line_tx_data,
    // Control to transceivers
    output wire [31:0] port_control,
    output wire [9:0]  port_advertise
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_HDR  = 2'h1;
    localparam [1:0] ST_TA   = 2'h2;
    localparam [1:0] ST_DATA = 2'h3;

    reg  [2:0]  mdc_sync_r;
    reg  [1:0]  mdio_sync_r;
    reg  [1:0]  state_r;
    reg  [5:0]  ones_r;
    reg  [4:0]  cnt_r;
    reg  [15:0] sr_r;
    reg  [15:0] rd_sr_r;
    reg         is_rd_r;
    reg         hit_r;
    reg         port_r;
    reg  [4:0]  transceiver_register_index_r;
    reg         mdio_o_r;
    reg         mdio_oe_r;
    reg         wr_pulse_r;
    reg  [15:0] wr_data_r;
    reg  [4:0]  glb_field_r;
    reg  [7:0]  hst_rdata_r;
    reg  [7:0]  line_tx_r;
    reg  [15:0] rd_word;
    reg  [7:0]  hst_rd_nxt;

    wire [31:0] ctl_all;
    wire [9:0]  adv_all;
    wire [63:0] ind_rd;
    wire [4:0]  addr1;
    wire [4:0]  addr2;
    wire        mdc_rise;
    wire        bit_in;
    wire [12:0] hdr;
    wire [1:0]  hdr_op;
    wire [4:0]  hdr_phy;
    wire [4:0]  hdr_reg;
    wire        hdr_m1;
    wire        hdr_m2;
    wire        hdr_ok;
    wire        hdr_port;

    // Pins pass two flops; the third stage only feeds edge detection
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mdc_sync_r  <= 3'h0;
            mdio_sync_r <= 2'h3;
        end else begin
            mdc_sync_r  <= {mdc_sync_r[1:0], mdc};
            mdio_sync_r <= {mdio_sync_r[0], mdio_i};
        end
    end

    assign mdc_rise = mdc_sync_r[1] & ~mdc_sync_r[2];
    assign bit_in   = mdio_sync_r[1];

    assign addr1 = glb_field_r;
    assign addr2 = glb_field_r + 5'h01;

    // Header: start bit 1, opcode, transceiver address, register index
    assign hdr      = {sr_r[11:0], bit_in};
    assign hdr_op   = hdr[11:10];
    assign hdr_phy  = hdr[9:5];
    assign hdr_reg  = hdr[4:0];
    assign hdr_m1   = (hdr_phy == addr1);
    assign hdr_m2   = (hdr_phy == addr2);
    assign hdr_port = ~hdr_m1;
    assign hdr_ok   = hdr[12] & (hdr_m1 | hdr_m2) &
                      ((hdr_op == `PMR_OP_RD) | (hdr_op == `PMR_OP_WR));

    // Read value of the addressed register
    always @* begin
        rd_word = 16'h0000;
        case (hdr_reg)
            `PMR_REG_CTL:
                rd_word = hdr_port ? ctl_all[31:16] : ctl_all[15:0];
            `PMR_REG_STS: begin
                rd_word    = `PMR_STS_FIX;
                rd_word[5] = neg_complete[hdr_port];
                rd_word[4] = far_end_fault[hdr_port];
                rd_word[2] = link_up[hdr_port];
            end
            `PMR_REG_IDH:
                rd_word = ID_HIGH;
            `PMR_REG_IDL:
                rd_word = ID_LOW;
            `PMR_REG_ADV: begin
                rd_word      = {11'h000, `PMR_ADV_SEL};
                rd_word[10]  = adv_all[hdr_port*5+4];
                rd_word[8:5] = hdr_port ? adv_all[8:5] : adv_all[3:0];
            end
            `PMR_REG_LPA: begin
                rd_word[10]  = partner_ability[hdr_port*5+4];
                rd_word[8:5] = hdr_port ? partner_ability[8:5] : partner_ability[3:0];
            end
            `PMR_REG_DIAG:
                rd_word = 16'h0000;
            `PMR_REG_SPEC:
                rd_word = 16'h0000;
            default:
                rd_word = 16'h0000;
        endcase
    end

    // Management frame engine
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r    <= ST_IDLE;
            ones_r     <= 6'h00;
            cnt_r      <= 5'h00;
            sr_r       <= 16'h0000;
            rd_sr_r    <= 16'h0000;
            is_rd_r    <= 1'b0;
            hit_r      <= 1'b0;
            port_r     <= 1'b0;
            transceiver_register_index_r    <= 5'h00;
            mdio_o_r   <= 1'b0;
            mdio_oe_r  <= 1'b0;
            wr_pulse_r <= 1'b0;
            wr_data_r  <= 16'h0000;
        end else begin
            wr_pulse_r <= 1'b0;
            if (mdc_rise) begin
                sr_r <= {sr_r[14:0], bit_in};
                case (state_r)
                    ST_IDLE: begin
                        if (bit_in) begin
                            if (ones_r != `PMR_PRE_LEN)
                                ones_r <= ones_r + 6'h01;
                        end else begin
                            if (ones_r == `PMR_PRE_LEN)
                                state_r <= ST_HDR;
                            ones_r <= 6'h00;
                            cnt_r  <= 5'h00;
                        end
                    end
                    ST_HDR: begin
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r == `PMR_HDR_LAST) begin
                            state_r <= ST_TA;
                            cnt_r   <= 5'h00;
                            hit_r   <= hdr_ok;
                            is_rd_r <= (hdr_op == `PMR_OP_RD);
                            port_r  <= hdr_port;
                            transceiver_register_index_r <= hdr_reg;
                            rd_sr_r <= rd_word;
                        end
                    end
                    ST_TA: begin
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r == 5'h00) begin
                            // Drive the low half of turnaround
                            mdio_oe_r <= hit_r & is_rd_r;
                            mdio_o_r  <= 1'b0;
                        end
                        if (cnt_r == `PMR_TA_LAST) begin
                            state_r  <= ST_DATA;
                            cnt_r    <= 5'h00;
                            mdio_o_r <= rd_sr_r[15];
                            rd_sr_r  <= {rd_sr_r[14:0], 1'b0};
                        end
                    end
                    ST_DATA: begin
                        cnt_r    <= cnt_r + 5'h01;
                        mdio_o_r <= rd_sr_r[15];
                        rd_sr_r  <= {rd_sr_r[14:0], 1'b0};
                        if (cnt_r == `PMR_DAT_LAST) begin
                            state_r    <= ST_IDLE;
                            mdio_oe_r  <= 1'b0;
                            mdio_o_r   <= 1'b0;
                            ones_r     <= 6'h00;
                            wr_pulse_r <= hit_r & ~is_rd_r;
                            wr_data_r  <= {sr_r[14:0], bit_in};
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign mdio_o  = mdio_o_r;
    assign mdio_oe = mdio_oe_r;

    // Global control register: address field only
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            glb_field_r <= `PMR_GLB_RST;
        else if (hst_we && (hst_addr == `PMR_HA_GLB))
            glb_field_r <= hst_wdata[7:3];
    end

    // Per-port register sets, indirect views and data path
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            wire [7:0]  base;
            wire [7:0]  off;
            wire        in_win;
            wire        ctl_we;
            wire        adv_we;
            wire [15:0] c;
            wire [4:0]  a;
            wire [3:0]  tx_sel;

            assign base   = (p == 0) ? `PMR_HA_P1 : `PMR_HA_P2;
            assign off    = hst_addr - base;
            assign in_win = (hst_addr >= base) && (off[7:2] == 6'h00);
            assign ctl_we = wr_pulse_r & (port_r == p) & (transceiver_register_index_r == `PMR_REG_CTL);
            assign adv_we = wr_pulse_r & (port_r == p) & (transceiver_register_index_r == `PMR_REG_ADV);

            pmr_port_regs u_regs (
                .clk         (clk),
                .rstn        (rstn),
                .mii_ctl_we  (ctl_we),
                .mii_adv_we  (adv_we),
                .mii_wdata   (wr_data_r),
                .ind_we      (hst_we & in_win),
                .ind_idx     (off[1:0]),
                .ind_wdata   (hst_wdata),
                .restart_ack (restart_ack[p]),
                .ctl_r       (c),
                .adv_r       (a)
            );

            assign ctl_all[p*16+15:p*16] = c;
            assign adv_all[p*5+4:p*5]    = a;

            // Byte-wide mirrors of the same bits
            assign ind_rd[p*32+7:p*32]    = {c[`PMR_B_NEGEN], c[`PMR_B_F100], c[`PMR_B_FULL], a};
            assign ind_rd[p*32+15:p*32+8] = {c[`PMR_B_LEDDIS], c[`PMR_B_TXDIS], c[`PMR_B_NEGRS],
                                             c[`PMR_B_FEFD], c[`PMR_B_PDN], c[`PMR_B_XDIS],
                                             c[`PMR_B_STRT], c[`PMR_B_LOOP]};
            assign ind_rd[p*32+23:p*32+16] = {1'b0, neg_complete[p], link_up[p],
                                              partner_ability[p*5+4:p*5]};
            assign ind_rd[p*32+31:p*32+24] = {c[`PMR_B_XALG], 6'h00, far_end_fault[p]};

            // Loopback in the other port turns this port's receive data around
            assign tx_sel = ctl_all[(1-p)*16+`PMR_B_LOOP] ? line_rx_data[p*4+3:p*4]
                                                          : mac_tx_data[p*4+3:p*4];

            always @(posedge clk or negedge rstn) begin
                if (!rstn)
                    line_tx_r[p*4+3:p*4] <= 4'h0;
                else if (c[`PMR_B_TXDIS])
                    line_tx_r[p*4+3:p*4] <= 4'h0;
                else
                    line_tx_r[p*4+3:p*4] <= tx_sel;
            end
        end
    endgenerate

    // Host read data, one cycle after the address
    always @* begin
        hst_rd_nxt = 8'h00;
        if (hst_addr == `PMR_HA_GLB)
            hst_rd_nxt = {glb_field_r, 3'h0};
        else if ((hst_addr >= `PMR_HA_P1) && (hst_addr < `PMR_HA_P1 + 8'h04))
            hst_rd_nxt = ind_rd[{hst_addr[1:0], 3'h0} +: 8];
        else if ((hst_addr >= `PMR_HA_P2) && (hst_addr < `PMR_HA_P2 + 8'h04))
            hst_rd_nxt = ind_rd[{1'b1, hst_addr[1:0], 3'h0} +: 8];
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            hst_rdata_r <= 8'h00;
        else
            hst_rdata_r <= hst_rd_nxt;
    end

    assign hst_rdata      = hst_rdata_r;
    assign line_tx_data   = line_tx_r;
    assign port_control   = ctl_all;
    assign port_advertise = adv_all;
endmodule // pmr_mgmt_bank

// ==== rtl/pmr_port_regs.v ====
`timescale 1ns/1ps
`include "pmr_consts.vh"
module pmr_port_regs (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // Management writes
    input  wire        mii_ctl_we,
    input  wire        mii_adv_we,
    input  wire [15:0] mii_wdata,
    // Host port writes
    input  wire        ind_we,
    input  wire [1:0]  ind_idx,
    input  wire [7:0]  ind_wdata,
    // Negotiation restart taken
    input  wire        restart_ack,
    // State
    output reg  [15:0] ctl_r,
    output reg  [4:0]  adv_r
);
    reg [15:0] ctl_nxt;
    reg [4:0]  adv_nxt;

    always @* begin
        ctl_nxt = ctl_r;
        adv_nxt = adv_r;
        if (restart_ack)
            ctl_nxt[`PMR_B_NEGRS] = 1'b0;
        // Writes come after the clear so a new restart request wins
        if (mii_ctl_we)
            ctl_nxt = mii_wdata & `PMR_CTL_WMSK;
        if (mii_adv_we)
            adv_nxt = {mii_wdata[10], mii_wdata[8:5]};
        if (ind_we) begin
            case (ind_idx)
                `PMR_IDX_ABIL: begin
                    ctl_nxt[`PMR_B_NEGEN] = ind_wdata[7];
                    ctl_nxt[`PMR_B_F100]  = ind_wdata[6];
                    ctl_nxt[`PMR_B_FULL]  = ind_wdata[5];
                    adv_nxt               = ind_wdata[4:0];
                end
                `PMR_IDX_CTRL: begin
                    ctl_nxt[`PMR_B_LEDDIS] = ind_wdata[7];
                    ctl_nxt[`PMR_B_TXDIS]  = ind_wdata[6];
                    ctl_nxt[`PMR_B_NEGRS]  = ind_wdata[5];
                    ctl_nxt[`PMR_B_FEFD]   = ind_wdata[4];
                    ctl_nxt[`PMR_B_PDN]    = ind_wdata[3];
                    ctl_nxt[`PMR_B_XDIS]   = ind_wdata[2];
                    ctl_nxt[`PMR_B_STRT]   = ind_wdata[1];
                    ctl_nxt[`PMR_B_LOOP]   = ind_wdata[0];
                end
                `PMR_IDX_SPEC: begin
                    ctl_nxt[`PMR_B_XALG] = ind_wdata[7];
                end
                default: begin
                    ctl_nxt = ctl_nxt;
                end
            endcase
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl_r <= `PMR_CTL_RST;
            adv_r <= `PMR_ADV_RST;
        end else begin
            ctl_r <= ctl_nxt;
            adv_r <= adv_nxt;
        end
    end
endmodule // pmr_port_regs

// ==== verification/pmr_mgmt_monitor.sv ====
`timescale 1ns/1ps
module pmr_mgmt_monitor (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Host port
    input wire logic [7:0]  hst_addr,
    input wire logic        hst_we,
    input wire logic [7:0]  hst_wdata,
    input wire logic [1:0]  restart_ack,
    // Data path and control
    input wire logic [7:0]  mac_tx_data,
    input wire logic [7:0]  line_rx_data,
    input wire logic [7:0]  line_tx_data,
    input wire logic [31:0] port_control
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    property p_rst_ctl;
        disable iff (1'b0) $rose(rstn) |-> port_control == 32'h10201020;
    endproperty
    a_rst_ctl: assert property (p_rst_ctl) else $error("control not at reset value");
    property p_ro_bits;
        (port_control & 32'h84C084C0) == 32'h0;
    endproperty
    a_ro_bits: assert property (p_ro_bits) else $error("read-only control bit set");
    property p_hst_wr;
        hst_we && hst_addr == 8'h1D |=> port_control[14] == $past(hst_wdata[0])
            && port_control[4] == $past(hst_wdata[1]) && port_control[2] == $past(hst_wdata[4]);
    endproperty
    a_hst_wr: assert property (p_hst_wr) else $error("host byte not applied");
    property p_loop1;
        port_control[14] && !port_control[17] |=> line_tx_data[7:4] == $past(line_rx_data[7:4]);
    endproperty
    a_loop1: assert property (p_loop1) else $error("port 1 loopback path wrong");
    property p_loop2;
        port_control[30] && !port_control[1] |=> line_tx_data[3:0] == $past(line_rx_data[3:0]);
    endproperty
    a_loop2: assert property (p_loop2) else $error("port 2 loopback path wrong");
    property p_norm;
        !port_control[30] && !port_control[1] |=> line_tx_data[3:0] == $past(mac_tx_data[3:0]);
    endproperty
    a_norm: assert property (p_norm) else $error("normal path wrong");
    property p_txdis;
        port_control[1] |=> line_tx_data[3:0] == 4'h0;
    endproperty
    a_txdis: assert property (p_txdis) else $error("transmit not disabled");
    property p_restart;
        restart_ack[0] && !hst_we |=> !port_control[9];
    endproperty
    a_restart: assert property (p_restart) else $error("restart bit not cleared");
endmodule // pmr_mgmt_monitor

bind pmr_mgmt_bank pmr_mgmt_monitor u_mon (
    .clk(clk), .rstn(rstn), .hst_addr(hst_addr), .hst_we(hst_we), .hst_wdata(hst_wdata),
    .restart_ack(restart_ack), .mac_tx_data(mac_tx_data), .line_rx_data(line_rx_data),
    .line_tx_data(line_tx_data), .port_control(port_control)
);

// ==== verification/pmr_mgmt_station.sv ====
`timescale 1ns/1ps
module pmr_mgmt_station (
    // Management wire
    output logic        mdc,
    output logic        drv,
    output logic        dout,
    input  wire logic   mdio,
    // Completed read
    output logic        rd_pulse,
    output logic [15:0] rd_word
);
    // Six core cycles per phase keeps the device's synchroniser well inside its limits
    localparam int HALF = 60;
    initial begin
        mdc = 1'b0;
        drv = 1'b0;
        dout = 1'b1;
        rd_pulse = 1'b0;
        rd_word = 16'h0000;
    end
    // Data changes while the clock is low, the line is sampled just before it rises
    task automatic bit_io(input logic d, input logic own, output logic s);
        drv = own;
        dout = d;
        #HALF s = mdio;
        mdc = 1'b1;
        #HALF mdc = 1'b0;
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd);
        logic [45:0] hdr;
        logic        s;
        hdr = {32'hFFFFFFFF, 2'b01, op, phy, ra};
        for (int i = 45; i >= 0; i--) bit_io(hdr[i], 1'b1, s);
        if (op == 2'b01) begin
            bit_io(1'b1, 1'b1, s);
            bit_io(1'b0, 1'b1, s);
            for (int i = 15; i >= 0; i--) bit_io(wd[i], 1'b1, s);
        end else begin
            bit_io(1'b1, 1'b0, s);
            bit_io(1'b1, 1'b0, s);
            for (int i = 15; i >= 0; i--) begin
                bit_io(1'b1, 1'b0, s);
                rd_word[i] = s;
            end
        end
        drv = 1'b0;
        #200 rd_pulse = (op == 2'b10);
        #10 rd_pulse = 1'b0;
    endtask
endmodule // pmr_mgmt_station

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`include "pmr_consts.vh"
module tb;
    localparam logic [15:0] ID_HI = 16'h1357; // Arbitrary value
    localparam logic [15:0] ID_LO = 16'h2468; // Arbitrary value
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  hst_addr, hst_wdata, mac_tx_data, line_rx_data;
    logic        hst_we, obs_pulse;
    logic [1:0]  link_up, neg_complete, far_end_fault, restart_ack, obs_sel;
    logic [9:0]  partner_ability;
    logic [15:0] r;
    wire         mdc, mdio_o, mdio_oe, s_drv, s_dout, rd_pulse;
    wire  [15:0] rd_word;
    wire  [7:0]  hst_rdata, line_tx_data;
    wire  [31:0] port_control;
    wire  [9:0]  port_advertise;
    // The management line has a pull-up
    wire         mdio = mdio_oe ? mdio_o : (s_drv ? s_dout : 1'b1);
    int          num_errors = 0;
    int          tests_run = 0;
    string       q_name[$];
    logic [31:0] q_exp[$];
    logic [4:0]  unsup[5] = '{5'h06, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
    always #5 clk = ~clk;
    pmr_mgmt_bank #(.ID_HIGH(ID_HI), .ID_LOW(ID_LO)) dut (
        .clk(clk), .rstn(rstn), .mdc(mdc), .mdio_i(mdio), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
        .hst_addr(hst_addr), .hst_we(hst_we), .hst_wdata(hst_wdata), .hst_rdata(hst_rdata),
        .link_up(link_up), .neg_complete(neg_complete), .far_end_fault(far_end_fault),
        .partner_ability(partner_ability), .restart_ack(restart_ack), .mac_tx_data(mac_tx_data),
        .line_rx_data(line_rx_data), .line_tx_data(line_tx_data), .port_control(port_control),
        .port_advertise(port_advertise));
    pmr_mgmt_station sta (.mdc(mdc), .drv(s_drv), .dout(s_dout), .mdio(mdio),
        .rd_pulse(rd_pulse), .rd_word(rd_word));
    task automatic check(input logic [31:0] got);
        tests_run++;
        if (q_exp.size() == 0 || got !== q_exp[0]) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", q_name[0], q_exp[0], got);
        end
        void'(q_name.pop_front());
        void'(q_exp.pop_front());
    endtask
    always @(posedge clk) begin
        if (rd_pulse === 1'b1) check({16'h0000, rd_word});
        if (obs_pulse) check(obs_sel == 0 ? port_control : (obs_sel == 3 ? {22'h0, port_advertise} :
            {24'h0, obs_sel == 1 ? hst_rdata : line_tx_data}));
    end
    task automatic note(input string nm, input logic [31:0] v);
        q_name.push_back(nm);
        q_exp.push_back(v);
    endtask
    task automatic observe(input logic [1:0] sel, input string nm, input logic [31:0] v);
        note(nm, v);
        @(negedge clk);
        obs_sel = sel;
        obs_pulse = 1'b1;
        @(negedge clk);
        obs_pulse = 1'b0;
    endtask
    task automatic mrd(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] v);
        note("mgmt read", {16'h0000, v});
        sta.frame(2'b10, phy, ra, 16'h0000);
    endtask
    task automatic mwr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] v);
        sta.frame(2'b01, phy, ra, v);
    endtask
    task automatic hwr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        hst_addr = a;
        hst_wdata = d;
        hst_we = 1'b1;
        @(negedge clk);
        hst_we = 1'b0;
    endtask
    task automatic hrd(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        hst_addr = a;
        observe(2'd1, "host read", {24'h0, v});
    endtask
    task automatic end_of_test();
        num_errors += q_exp.size();
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // About thirty-three frames of some eight microseconds each; allow nearly twice as much
    initial begin
        #500_000;
        num_errors++;
        end_of_test();
    end
    initial begin
        {hst_addr, hst_wdata, hst_we, restart_ack, mac_tx_data, line_rx_data} = '0;
        {obs_pulse, obs_sel, partner_ability} = '0;
        {link_up, neg_complete, far_end_fault} = 6'b010101;
        void'($urandom(32'h0850));
        repeat (3) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        mrd(5'h01, `PMR_REG_CTL, `PMR_CTL_RST);
        mrd(5'h02, `PMR_REG_CTL, `PMR_CTL_RST);
        mrd(5'h03, `PMR_REG_CTL, 16'hFFFF);
        mrd(5'h01, `PMR_REG_IDH, ID_HI);
        mrd(5'h02, `PMR_REG_IDL, ID_LO);
        mrd(5'h01, `PMR_REG_STS, `PMR_STS_FIX | 16'h0034);
        mrd(5'h02, `PMR_REG_STS, `PMR_STS_FIX);
        mrd(5'h01, `PMR_REG_ADV, 16'h05E1);
        foreach (unsup[i]) begin
            mwr(5'h02, unsup[i], 16'hFFFF);
            mrd(5'h02, unsup[i], 16'h0000);
        end
        mwr(5'h01, `PMR_REG_CTL, 16'hFFFF);
        mrd(5'h01, `PMR_REG_CTL, `PMR_CTL_WMSK);
        @(negedge clk) restart_ack = 2'b01;
        @(negedge clk) restart_ack = 2'b00;
        observe(2'd0, "control word", {`PMR_CTL_RST, `PMR_CTL_WMSK & 16'hFDFF});
        r = 16'($urandom());
        mwr(5'h02, `PMR_REG_CTL, r);
        mwr(5'h02, `PMR_REG_IDH, ~r);
        mrd(5'h02, `PMR_REG_CTL, r & `PMR_CTL_WMSK);
        mrd(5'h02, `PMR_REG_IDH, ID_HI);
        for (int c = 0; c < 3; c++) begin
            mwr(5'h01, `PMR_REG_CTL, c == 0 ? 16'h4000 : (c == 2 ? 16'h0002 : 16'h0000));
            mwr(5'h02, `PMR_REG_CTL, c == 1 ? 16'h4000 : 16'h0000);
            @(negedge clk);
            mac_tx_data = 8'($urandom());
            line_rx_data = 8'($urandom());
            observe(2'd2, "line data", {24'h0, c == 0 ? line_rx_data[7:4] : mac_tx_data[7:4],
                c == 1 ? line_rx_data[3:0] : (c == 2 ? 4'h0 : mac_tx_data[3:0])});
        end
        hwr(`PMR_HA_GLB, 8'h28);
        hrd(`PMR_HA_GLB, 8'h28);
        mrd(5'h05, `PMR_REG_CTL, 16'h0002);
        mrd(5'h06, `PMR_REG_CTL, 16'h0000);
        mrd(5'h01, `PMR_REG_CTL, 16'hFFFF);
        hwr(8'h1D, 8'h96);
        hwr(8'h30, 8'hFF);
        hwr(8'h1E, 8'hFF);
        observe(2'd0, "control word", 32'h0000001D);
        hrd(8'h30, 8'h00);
        hwr(`PMR_HA_P2, 8'hE3);
        hrd(`PMR_HA_P2, 8'hE3);
        observe(2'd3, "advertise", 32'h0000007F);
        observe(2'd0, "control word", 32'h3100001D);
        end_of_test();
    end
endmodule // tb
